// ==== rtl/scm_pkg.sv ====
// Package for the serial clock-mode and time-slot block: constants, modes and carrier types.
// Function
// - Two channels run independently, each with own divider and recovery, one oscillator.
// - Eight clock modes per channel, chosen by a field of channel_config_one.
// - Mode 0 takes receive and transmit clocks straight from their own pins.
// - Mode 1 clocks both ways from receive pin; auxiliary and transmit pins are strobes.
// - Mode 2: divider on receive pin feeds recovery; transmit from pin or divider/16.
// - Mode 2 with divider/16 transmit and output bit set drives that clock out.
// - Mode 3: recovery circuit makes both clocks from the divided receive pin clock.
// - Mode 4: oscillator clocks both directions directly, optionally driven out.
// - Mode 6 equals mode 2 but the divider runs from the oscillator.
// - Mode 7 equals mode 3 but the divider runs from the oscillator.
// - Transmit clock pin becomes output only when transmit_pin_output_bit is set.
// - Recovery reference is the divider, factor 1 or 2, 4, 6 up to 2048.
// - Each channel's system clock is derived from its transmit clock.
// - Mode 5 moves data only inside windows 1 to 256 bits wide, per direction.
// - Slot location per direction: 256 slots plus 0..1 shift, 9 location bits.
// - Window opens 1 to 512 clocks after frame sync, lasts the programmed width.
// - Mode 5 drives the transmit clock pin low throughout the transmit window.
// - Send-request drops after second-last closing flag bit ending a window.
// - Mode 5 samples clear-to-send always; deassertion stops transmission at once.
package scm_pkg;

  localparam int NCH = 2;

  // Clock modes in register order, 0 to 7.
  typedef enum logic [2:0] {
    SCM_EXT, SCM_STROBE, SCM_CLOCK_RECOVERY_CIRCUIT_RX, SCM_CLOCK_RECOVERY_CIRCUIT_BOTH,
    SCM_OSC, SCM_SLOT, SCM_OSC_CLOCK_RECOVERY_CIRCUIT_RX, SCM_OSC_CLOCK_RECOVERY_CIRCUIT_BOTH
  } scm_mode_e;

  // Register byte offsets inside one channel, and the stride between channels.
  localparam logic [7:0] OFF_CONFIG_ONE  = 8'h00;
  localparam logic [7:0] OFF_CONFIG_TWO  = 8'h04;
  localparam logic [7:0] OFF_BAUD_DIV    = 8'h08;
  localparam logic [7:0] OFF_RX_WIDTH    = 8'h0c;
  localparam logic [7:0] OFF_TX_WIDTH    = 8'h10;
  localparam logic [7:0] OFF_RX_LOC      = 8'h14;
  localparam logic [7:0] OFF_TX_LOC      = 8'h18;
  localparam logic [7:0] OFF_STATUS      = 8'h1c;
  localparam logic [7:0] CH_STRIDE       = 8'h20;
  localparam logic [7:0] MAP_END         = 8'h40;

  // Bit positions in channel_config_two.
  localparam int C2_TSS    = 0;
  localparam int C2_TIO    = 1;
  localparam int C2_TRANSMIT_SHIFT_LSB   = 2;
  localparam int C2_RECEIVE_SHIFT_LSB   = 3;
  localparam int C2_DIVEN  = 4;
  localparam int C2_DIVHI  = 6;

  // Synchroniser lanes of one channel's pin inputs; the first struct field is the top bit.
  localparam int P_RXC = 4;
  localparam int P_AUX = 3;
  localparam int P_TXC = 2;
  localparam int P_RXD = 1;
  localparam int P_CTS = 0;
  localparam int NPIN  = 5;

  // Recovery circuit: 16 reference ticks per bit, sampling at mid-cell.
  localparam logic [3:0] CLOCK_RECOVERY_CIRCUIT_MID  = 4'h8;
  localparam logic [3:0] DIV16_END = 4'hf;
  localparam logic [9:0] POS_MAX   = 10'h3ff;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Pins of one channel as seen by the block.
  typedef struct packed {
    logic rx_clk;      // receive_clock_pin
    logic aux_clk;     // auxiliary_clock_pin
    logic tx_clk_in;   // transmit_clock_pin, input side
    logic rx_data;
    logic cts_n;
  } scm_pin_in_s;

  // Link-side outputs of one channel.
  typedef struct packed {
    logic rx_bit_en;
    logic tx_bit_en;
    logic rx_window;
    logic tx_window;
    logic send_request;
    logic tx_clk_out;
    logic tx_clk_oe;
  } scm_pin_out_s;

  // Transmitter status fed in from same-clock logic.
  typedef struct packed {
    logic busy;
    logic flag_second_last;
  } scm_tx_stat_s;

  // Full per-channel state.
  typedef struct packed {
    scm_mode_e           mode;
    logic [7:0]          cfg2;
    logic [7:0]          div_lo;
    logic [7:0]          rx_w;
    logic [7:0]          tx_w;
    logic [7:0]          rx_loc;
    logic [7:0]          tx_loc;
    logic [NPIN-1:0]     s1;
    logic [NPIN-1:0]     s2;
    logic [NPIN-1:0]     prev;
    logic [10:0]         brg_cnt;
    logic [3:0]          clock_recovery_circuit_cnt;
    logic [3:0]          div16;
    logic [9:0]          pos;
    logic                drop;
    scm_pin_out_s        out;
  } scm_ch_s;

endpackage : scm_pkg

// ==== rtl/scm_clock_slot.sv ====
// Two-channel clock-mode selection and time-slot window logic with an AXI4-Lite register slave.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
module scm_clock_slot (
  // Clock and reset
  input  wire  logic                                     aclk,
  input  wire  logic                                     aresetn,
  // AXI4-Lite write address and data
  input  wire  logic                                     awvalid,
  output logic                                           awready,
  input  wire  logic [7:0]                               awaddr,
  input  wire  logic [2:0]                               awprot,
  input  wire  logic                                     wvalid,
  output logic                                           wready,
  input  wire  logic [31:0]                              wdata,
  input  wire  logic [3:0]                               wstrb,
  // AXI4-Lite write response
  output logic                                           bvalid,
  input  wire  logic                                     bready,
  output logic [1:0]                                     bresp,
  // AXI4-Lite read
  input  wire  logic                                     arvalid,
  output logic                                           arready,
  input  wire  logic [7:0]                               araddr,
  input  wire  logic [2:0]                               arprot,
  output logic                                           rvalid,
  input  wire  logic                                     rready,
  output logic [31:0]                                    rdata,
  output logic [1:0]                                     rresp,
  // Shared oscillator input and per-channel pins
  input  wire  logic                                     internal_oscillator,
  input  wire  scm_pkg::scm_pin_in_s  [scm_pkg::NCH-1:0] pin_in,
  output scm_pkg::scm_pin_out_s       [scm_pkg::NCH-1:0] pin_out,
  // Transmitter status per channel
  input  wire  scm_pkg::scm_tx_stat_s [scm_pkg::NCH-1:0] tx_stat
);

  typedef struct packed {
    scm_pkg::scm_ch_s [scm_pkg::NCH-1:0] ch;
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_prev;
    logic        awready;
    logic        wready;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } scm_state_s;

  localparam int NPIN_W = scm_pkg::NPIN;

  scm_state_s st_r;
  scm_state_s st_nxt;

  // Next-state logic for the bus slave and both channels.
  always_comb begin
    logic        osc_rise;
    logic [7:0]  off;
    logic        hit_ch;
    logic        ch_sel;
    logic [31:0] rd;
    logic        mapped;
    logic [NPIN_W-1:0] rise;
    logic        rxd_edge;
    logic        brg_in;
    logic        brg_tick;
    logic [10:0] fac_m1;
    logic        clock_recovery_circuit_tick;
    logic        div16_tick;
    logic [9:0]  pos_n;
    logic [10:0] rx_end;
    logic [10:0] tx_end;
    logic        rx_win;
    logic        tx_win;
    logic        rx_src;
    logic        tx_src;
    logic        cts_ok;
    logic        transmit_pin_output_bit;
    st_nxt     = st_r;
    osc_rise   = 1'b0;
    off        = 8'h00;
    hit_ch     = 1'b0;
    ch_sel     = 1'b0;
    rd         = 32'h0000_0000;
    mapped     = 1'b0;
    rise       = '0;
    rxd_edge   = 1'b0;
    brg_in     = 1'b0;
    brg_tick   = 1'b0;
    fac_m1     = 11'h000;
    clock_recovery_circuit_tick  = 1'b0;
    div16_tick = 1'b0;
    pos_n      = 10'h000;
    rx_end     = 11'h000;
    tx_end     = 11'h000;
    rx_win     = 1'b0;
    tx_win     = 1'b0;
    rx_src     = 1'b0;
    tx_src     = 1'b0;
    cts_ok     = 1'b0;
    transmit_pin_output_bit        = 1'b0;

    // Oscillator is shared by both channels; the first stage feeds only the second.
    st_nxt.osc_s1   = internal_oscillator;
    st_nxt.osc_s2   = st_r.osc_s1;
    st_nxt.osc_prev = st_r.osc_s2;
    osc_rise        = st_r.osc_s2 & ~st_r.osc_prev;

    // Capture write address and data independently; either may arrive first.
    if (awvalid && st_r.awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = awaddr;
    end
    if (wvalid && st_r.wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = wdata;
      st_nxt.w_strb = wstrb;
    end
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // Perform the write once both halves are held and the response slot is free.
    if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
      ch_sel = st_r.aw_addr[5];
      off    = st_r.aw_addr & (scm_pkg::CH_STRIDE - 8'h01);
      hit_ch = st_r.aw_addr < scm_pkg::MAP_END;
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = scm_pkg::RESP_OKAY;
      // Only byte lane 0 carries register data; upper lanes are ignored.
      if (!hit_ch) begin
        st_nxt.bresp = scm_pkg::RESP_SLVERR;
      end else if (!st_r.w_strb[0]) begin
        st_nxt.bresp = scm_pkg::RESP_OKAY;
      end else if (off == scm_pkg::OFF_CONFIG_ONE) begin
        st_nxt.ch[ch_sel].mode = scm_pkg::scm_mode_e'(st_r.w_data[2:0]);
      end else if (off == scm_pkg::OFF_CONFIG_TWO) begin
        st_nxt.ch[ch_sel].cfg2 = st_r.w_data[7:0];
      end else if (off == scm_pkg::OFF_BAUD_DIV) begin
        st_nxt.ch[ch_sel].div_lo = st_r.w_data[7:0];
      end else if (off == scm_pkg::OFF_RX_WIDTH) begin
        st_nxt.ch[ch_sel].rx_w = st_r.w_data[7:0];
      end else if (off == scm_pkg::OFF_TX_WIDTH) begin
        st_nxt.ch[ch_sel].tx_w = st_r.w_data[7:0];
      end else if (off == scm_pkg::OFF_RX_LOC) begin
        st_nxt.ch[ch_sel].rx_loc = st_r.w_data[7:0];
      end else if (off == scm_pkg::OFF_TX_LOC) begin
        st_nxt.ch[ch_sel].tx_loc = st_r.w_data[7:0];
      end else if (off != scm_pkg::OFF_STATUS) begin
        st_nxt.bresp = scm_pkg::RESP_SLVERR;
      end
    end

    // Reads answer one cycle after the address is taken.
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (arvalid && st_r.arready) begin
      ch_sel = araddr[5];
      off    = araddr & (scm_pkg::CH_STRIDE - 8'h01);
      mapped = araddr < scm_pkg::MAP_END;
      if (!mapped) begin
        rd = 32'h0000_0000;
      end else if (off == scm_pkg::OFF_CONFIG_ONE) begin
        rd = {29'h0, st_r.ch[ch_sel].mode};
      end else if (off == scm_pkg::OFF_CONFIG_TWO) begin
        rd = {24'h00_0000, st_r.ch[ch_sel].cfg2};
      end else if (off == scm_pkg::OFF_BAUD_DIV) begin
        rd = {24'h00_0000, st_r.ch[ch_sel].div_lo};
      end else if (off == scm_pkg::OFF_RX_WIDTH) begin
        rd = {24'h00_0000, st_r.ch[ch_sel].rx_w};
      end else if (off == scm_pkg::OFF_TX_WIDTH) begin
        rd = {24'h00_0000, st_r.ch[ch_sel].tx_w};
      end else if (off == scm_pkg::OFF_RX_LOC) begin
        rd = {24'h00_0000, st_r.ch[ch_sel].rx_loc};
      end else if (off == scm_pkg::OFF_TX_LOC) begin
        rd = {24'h00_0000, st_r.ch[ch_sel].tx_loc};
      end else if (off == scm_pkg::OFF_STATUS) begin
        rd = {12'h000, st_r.ch[ch_sel].pos, 3'h0, st_r.ch[ch_sel].out};
      end else begin
        mapped = 1'b0;
      end
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd;
      st_nxt.rresp  = mapped ? scm_pkg::RESP_OKAY : scm_pkg::RESP_SLVERR;
    end
    st_nxt.awready = !st_nxt.aw_held;
    st_nxt.wready  = !st_nxt.w_held;
    st_nxt.arready = !st_nxt.rvalid;

    // Each channel keeps its own divider, recovery counter and slot counter.
    for (int i = 0; i < scm_pkg::NCH; i++) begin
      st_nxt.ch[i].s1   = pin_in[i];
      st_nxt.ch[i].s2   = st_r.ch[i].s1;
      st_nxt.ch[i].prev = st_r.ch[i].s2;
      rise     = st_r.ch[i].s2 & ~st_r.ch[i].prev;
      rxd_edge = st_r.ch[i].s2[scm_pkg::P_RXD] ^ st_r.ch[i].prev[scm_pkg::P_RXD];
      transmit_pin_output_bit      = st_r.ch[i].cfg2[scm_pkg::C2_TIO];
      cts_ok   = !st_r.ch[i].s2[scm_pkg::P_CTS];

      // Divider input: oscillator in modes 6 and 7, receive pin otherwise.
      if (st_r.ch[i].mode == scm_pkg::SCM_OSC_CLOCK_RECOVERY_CIRCUIT_RX || st_r.ch[i].mode == scm_pkg::SCM_OSC_CLOCK_RECOVERY_CIRCUIT_BOTH) begin
        brg_in = osc_rise;
      end else begin
        brg_in = rise[scm_pkg::P_RXC];
      end
      // Factor 1 when disabled, else 2*(n+1) for a 10-bit n, reaching 2048.
      fac_m1 = st_r.ch[i].cfg2[scm_pkg::C2_DIVEN] ?
               {st_r.ch[i].cfg2[scm_pkg::C2_DIVHI +: 2], st_r.ch[i].div_lo, 1'b1} : 11'h000;
      brg_tick = brg_in && (st_r.ch[i].brg_cnt >= fac_m1);
      if (brg_tick) begin
        st_nxt.ch[i].brg_cnt = 11'h000;
      end else if (brg_in) begin
        st_nxt.ch[i].brg_cnt = st_r.ch[i].brg_cnt + 11'h001;
      end

      // Recovery: a data edge restarts the bit cell, the receive clock fires mid-cell.
      // This is a plain phase reset; it trades jitter filtering for small area.
      clock_recovery_circuit_tick = brg_tick && (st_r.ch[i].clock_recovery_circuit_cnt == scm_pkg::CLOCK_RECOVERY_CIRCUIT_MID);
      if (rxd_edge) begin
        st_nxt.ch[i].clock_recovery_circuit_cnt = 4'h0;
      end else if (brg_tick) begin
        st_nxt.ch[i].clock_recovery_circuit_cnt = st_r.ch[i].clock_recovery_circuit_cnt + 4'h1;
      end
      div16_tick = brg_tick && (st_r.ch[i].div16 == scm_pkg::DIV16_END);
      if (brg_tick) begin
        st_nxt.ch[i].div16 = st_r.ch[i].div16 + 4'h1;
      end

      // Frame position: frame sync on the auxiliary pin restarts the count.
      if (rise[scm_pkg::P_AUX]) begin
        pos_n = 10'h000;
      end else if (rise[scm_pkg::P_RXC] && st_r.ch[i].pos != scm_pkg::POS_MAX) begin
        pos_n = st_r.ch[i].pos + 10'h001;
      end else begin
        pos_n = st_r.ch[i].pos;
      end
      st_nxt.ch[i].pos = pos_n;
      // Window spans positions L+1 to L+W+1 with a 9-bit location L.
      rx_end = {2'b00, st_r.ch[i].rx_loc, st_r.ch[i].cfg2[scm_pkg::C2_RECEIVE_SHIFT_LSB]} + {3'b000, st_r.ch[i].rx_w} + 11'h001;
      tx_end = {2'b00, st_r.ch[i].tx_loc, st_r.ch[i].cfg2[scm_pkg::C2_TRANSMIT_SHIFT_LSB]} + {3'b000, st_r.ch[i].tx_w} + 11'h001;
      rx_win = (pos_n > {st_r.ch[i].rx_loc, st_r.ch[i].cfg2[scm_pkg::C2_RECEIVE_SHIFT_LSB]}) && ({1'b0, pos_n} <= rx_end);
      tx_win = (pos_n > {st_r.ch[i].tx_loc, st_r.ch[i].cfg2[scm_pkg::C2_TRANSMIT_SHIFT_LSB]}) && ({1'b0, pos_n} <= tx_end);

      // Per-mode clock sources and transmit clock pin function.
      st_nxt.ch[i].out.tx_clk_oe  = 1'b0;
      st_nxt.ch[i].out.tx_clk_out = 1'b0;
      rx_win = rx_win && (st_r.ch[i].mode == scm_pkg::SCM_SLOT);
      tx_win = tx_win && (st_r.ch[i].mode == scm_pkg::SCM_SLOT);
      case (st_r.ch[i].mode)
        scm_pkg::SCM_EXT: begin
          rx_src = rise[scm_pkg::P_RXC];
          tx_src = rise[scm_pkg::P_TXC];
        end
        scm_pkg::SCM_STROBE: begin
          rx_src = rise[scm_pkg::P_RXC] && st_r.ch[i].s2[scm_pkg::P_AUX];
          tx_src = rise[scm_pkg::P_RXC] && st_r.ch[i].s2[scm_pkg::P_TXC];
        end
        scm_pkg::SCM_CLOCK_RECOVERY_CIRCUIT_RX, scm_pkg::SCM_OSC_CLOCK_RECOVERY_CIRCUIT_RX: begin
          rx_src = clock_recovery_circuit_tick;
          if (st_r.ch[i].cfg2[scm_pkg::C2_TSS]) begin
            tx_src = div16_tick;
            st_nxt.ch[i].out.tx_clk_oe  = transmit_pin_output_bit;
            st_nxt.ch[i].out.tx_clk_out = !st_r.ch[i].div16[3];
          end else begin
            tx_src = rise[scm_pkg::P_TXC];
          end
        end
        scm_pkg::SCM_CLOCK_RECOVERY_CIRCUIT_BOTH, scm_pkg::SCM_OSC_CLOCK_RECOVERY_CIRCUIT_BOTH: begin
          rx_src = clock_recovery_circuit_tick;
          tx_src = clock_recovery_circuit_tick;
          st_nxt.ch[i].out.tx_clk_oe  = transmit_pin_output_bit;
          st_nxt.ch[i].out.tx_clk_out = st_r.ch[i].clock_recovery_circuit_cnt[3];
        end
        scm_pkg::SCM_OSC: begin
          rx_src = osc_rise;
          tx_src = osc_rise;
          st_nxt.ch[i].out.tx_clk_oe  = transmit_pin_output_bit;
          st_nxt.ch[i].out.tx_clk_out = st_r.osc_s2;
        end
        default: begin
          // Time-slot mode: shared receive pin clock gated by the windows; clear-to-send
          // is looked at every cycle so a drop stops the transmitter at once.
          rx_src = rise[scm_pkg::P_RXC] && rx_win;
          tx_src = rise[scm_pkg::P_RXC] && tx_win && cts_ok;
          st_nxt.ch[i].out.tx_clk_oe  = transmit_pin_output_bit;
          st_nxt.ch[i].out.tx_clk_out = !tx_win;
        end
      endcase

      // The transmit bit enable doubles as the channel's system clock enable.
      st_nxt.ch[i].out.rx_bit_en = rx_src;
      st_nxt.ch[i].out.tx_bit_en = tx_src;
      st_nxt.ch[i].out.rx_window = rx_win;
      st_nxt.ch[i].out.tx_window = tx_win;

      // Send-request falls early when the second-last flag bit closes a window.
      if (!tx_stat[i].busy) begin
        st_nxt.ch[i].drop = 1'b0;
      end else if (tx_src && tx_stat[i].flag_second_last && (st_r.ch[i].mode == scm_pkg::SCM_SLOT)
                   && ({1'b0, pos_n} == tx_end)) begin
        st_nxt.ch[i].drop = 1'b1;
      end
      st_nxt.ch[i].out.send_request = tx_stat[i].busy && !st_nxt.ch[i].drop;
    end
  end

  // State register; synchronous active-low reset clears everything.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign awready = st_r.awready;
  assign wready  = st_r.wready;
  assign bvalid  = st_r.bvalid;
  assign bresp   = st_r.bresp;
  assign arready = st_r.arready;
  assign rvalid  = st_r.rvalid;
  assign rdata   = st_r.rdata;
  assign rresp   = st_r.rresp;
  for (genvar g = 0; g < scm_pkg::NCH; g++) begin : g_out
    assign pin_out[g] = st_r.ch[g].out;
  end

  // A write taken on both channels is answered within three cycles.
  sequence aw_taken_s;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence b_answer_s;
    ##[1:3] bvalid;
  endsequence
  write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn) aw_taken_s |-> b_answer_s)
    else $error("write response missing");

  // Per-channel checks.
  for (genvar g = 0; g < scm_pkg::NCH; g++) begin : g_chk
    sequence in_mode_s(logic [2:0] m);
      $past(st_r.ch[g].mode) == m;
    endsequence
    ext_tx_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (in_mode_s(3'h0) and st_r.ch[g].out.tx_bit_en)
        |-> $past(st_r.ch[g].s2[scm_pkg::P_TXC] && !st_r.ch[g].prev[scm_pkg::P_TXC]))
      else $error("mode 0 transmit enable without pin edge");
    strobe_rx_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (in_mode_s(3'h1) and st_r.ch[g].out.rx_bit_en) |-> $past(st_r.ch[g].s2[scm_pkg::P_AUX]))
      else $error("mode 1 receive enable without strobe");
    div16_tx_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (in_mode_s(3'h2) and $past(st_r.ch[g].cfg2[0]) && st_r.ch[g].out.tx_bit_en) |-> st_r.ch[g].div16 == 4'h0)
      else $error("divided transmit clock out of step");
    osc_both_a: assert property (@(posedge aclk) disable iff (!aresetn)
      in_mode_s(3'h4) |-> st_r.ch[g].out.rx_bit_en == st_r.ch[g].out.tx_bit_en)
      else $error("mode 4 clocks differ");
    pin_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.ch[g].out.tx_clk_oe |-> $past(st_r.ch[g].cfg2[1]))
      else $error("transmit pin driven without output bit");
    slot_mark_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (in_mode_s(3'h5) and st_r.ch[g].out.tx_clk_oe) |-> st_r.ch[g].out.tx_clk_out == !st_r.ch[g].out.tx_window)
      else $error("slot marker not low in window");
    rx_window_a: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.ch[g].out.rx_window |-> st_r.ch[g].pos > {$past(st_r.ch[g].rx_loc), $past(st_r.ch[g].cfg2[3])})
      else $error("receive window opened early");
    cts_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (in_mode_s(3'h5) and st_r.ch[g].out.tx_bit_en) |-> $past(!st_r.ch[g].s2[scm_pkg::P_CTS]))
      else $error("transmit enabled with clear-to-send inactive");
    send_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.ch[g].out.send_request |-> $past(tx_stat[g].busy) && !st_r.ch[g].drop)
      else $error("send-request without busy transmitter");
  end

endmodule : scm_clock_slot

// ==== bench/scm_line_model.sv ====
// Line-side model: shared bit clock, frame sync and oscillator for both channels.
module scm_line_model (
  // Clock
  input  wire logic                                   aclk,
  // Clear-to-send levels set by the bench, active low
  input  wire logic [1:0]                             cts_n,
  // Pins towards the block
  output scm_pkg::scm_pin_in_s [scm_pkg::NCH-1:0]     pins,
  output logic                                        osc
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned t      = 0;
  logic        clk_q  = 1'b0;
  logic        sync_q = 1'b0;
  // A bit period is 12 cycles and a frame is 32 bits.
  // Sync rises in the low phase of the clock, so it never races a clock edge.
  always_ff @(posedge aclk) begin
    t      <= (t == 383) ? 0 : t + 1;
    clk_q  <= (t % 12) < 6;
    sync_q <= t >= 380;
    osc    <= (t % 4) < 2;
  end
  // Channel 0's transmit pin idles high as if pulled up, since the block drives it there.
  // Channel 1 gets the bit clock on its transmit pin, equal in rate to its receive clock.
  // Send-request is never used here as a line-driver enable.
  for (genvar c = 0; c < scm_pkg::NCH; c++) begin : g_ch
    assign pins[c] = '{rx_clk: clk_q, aux_clk: sync_q, tx_clk_in: (c == 1) ? clk_q : 1'b1,
                       rx_data: t[3], cts_n: cts_n[c]};
  end
endmodule : scm_line_model

// ==== bench/scm_clock_slot_tb.sv ====
// Self-checking bench for the clock-mode and time-slot block.
module scm_clock_slot_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, osc;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp, r, cts_n = 2'b11;
  scm_pkg::scm_pin_in_s [1:0] pin_in;
  scm_pkg::scm_pin_out_s [1:0] pin_out;
  scm_pkg::scm_tx_stat_s [1:0] tx_stat = '0;
  int num_errors = 0, n_checks = 0, cyc = 0, pos = 0, n_rx = 0, n_rise = 0, n_tx = 0, n_t1 = 0;
  int tl, rl, tw, rw, r0, k0, t0, u0;
  int vd[6];
  logic [7:0] ad[6] = '{scm_pkg::OFF_CONFIG_TWO, scm_pkg::OFF_TX_LOC, scm_pkg::OFF_RX_LOC,
                        scm_pkg::OFF_TX_WIDTH, scm_pkg::OFF_RX_WIDTH, scm_pkg::OFF_CONFIG_ONE};
  scm_clock_slot DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .internal_oscillator(osc),
    .pin_in(pin_in), .pin_out(pin_out), .tx_stat(tx_stat));
  scm_line_model LINE (.aclk(aclk), .cts_n(cts_n), .pins(pin_in), .osc(osc));
  // Clock of 100 ns period.
  initial forever #50 aclk = ~aclk;
  // Reference slot position and pulse tallies, rebuilt from the line stimulus.
  always @(posedge pin_in[0].aux_clk) pos = 0;
  always @(posedge pin_in[0].rx_clk) begin pos++; n_rise++; end
  // Cycle count cuts a hang short; pulse tallies count one per enable cycle.
  always @(posedge aclk) begin
    cyc++;
    n_rx += int'(pin_out[1].rx_bit_en === 1'b1);
    n_tx += int'(pin_out[0].tx_bit_en === 1'b1);
    n_t1 += int'(pin_out[1].tx_bit_en === 1'b1);
    if (cyc == 20000) begin num_errors++; stop_test(); end
  end
  function automatic logic inw(input int l, input int w);
    return pos > l && pos <= l + w + 1;
  endfunction : inw
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin num_errors++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end
  endtask : chk
  // Write: address and data offered together, each released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    fork
      begin do @(posedge aclk); while (awready !== 1'b1); awvalid <= 1'b0; end
      begin do @(posedge aclk); while (wready !== 1'b1); wvalid <= 1'b0; end
    join
    do @(posedge aclk); while (bvalid !== 1'b1);
    s = bresp; bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] es);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    chk(rdata, e); chk(32'(rresp), 32'(es));
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  initial begin
    void'($urandom(32'hd3b0_31d4));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // Configuration words reset to zero; an unmapped word answers with an error.
    for (int a = 0; a < 64; a += 4) if (a % 32 != 28) rd(8'(a), 0, scm_pkg::RESP_OKAY);
    rd(scm_pkg::MAP_END, 0, scm_pkg::RESP_SLVERR);
    wr(scm_pkg::MAP_END, 32'h0000_00ff, r);
    chk(32'(r), 32'(scm_pkg::RESP_SLVERR));
    $display("test registers done");
    // Channel 0 in slot mode with random slot places; channel 1 stays on external clocks.
    // Widths stay under 8 bits, so no extended transparent framing is used here.
    tl = $urandom_range(7); rl = $urandom_range(7); tw = $urandom_range(3); rw = $urandom_range(3);
    vd = '{2 + 4 * (tl % 2) + 8 * (rl % 2), tl / 2, rl / 2, tw, rw, 5};
    foreach (vd[i]) wr(ad[i], 32'(vd[i]), r);
    rd(scm_pkg::CH_STRIDE + scm_pkg::OFF_TX_WIDTH, 0, scm_pkg::RESP_OKAY);
    rd(ad[3], 32'(tw), scm_pkg::RESP_OKAY);
    cts_n <= 2'b10; tx_stat <= 4'b0010;
    @(posedge pin_in[0].aux_clk);
    r0 = n_rx; k0 = n_rise; t0 = n_tx;
    u0 = n_t1;
    repeat (64) begin
      @(negedge pin_in[0].rx_clk);
      repeat (3) @(posedge aclk);
      chk(32'(pin_out[0].tx_window), 32'(inw(tl, tw)));
      chk(32'(pin_out[0].rx_window), 32'(inw(rl, rw)));
      chk({pin_out[0].tx_clk_oe, pin_out[0].tx_clk_out}, {1'b1, !inw(tl, tw)});
      chk(32'(pin_out[1].rx_window), 0);
      chk(32'(pin_out[0].send_request), 1);
    end
    chk(32'(n_rx - r0), 32'(n_rise - k0));
    chk(32'(n_tx > t0), 1);
    chk(32'(n_t1 - u0), 32'(n_rise - k0));
    $display("test slots done");
    // Every bit marked second-last: the first window end drops send-request until busy falls.
    tx_stat <= 4'b0011;
    repeat (40) @(negedge pin_in[0].rx_clk);
    chk(32'(pin_out[0].send_request), 0);
    tx_stat <= 4'b0000;
    repeat (6) @(posedge aclk);
    tx_stat <= 4'b0010;
    repeat (3) @(posedge aclk);
    chk(32'(pin_out[0].send_request), 1);
    $display("test send request done");
    // Clear-to-send released: from eight cycles on, no transmit enable comes in 40 bits, windows included.
    cts_n <= 2'b11;
    repeat (8) @(posedge aclk);
    t0 = n_tx;
    repeat (40) @(negedge pin_in[0].rx_clk);
    chk(32'(n_tx - t0), 0);
    $display("test clear to send done");
    // Channel 1 walks every mode with source select and pin output set; only modes 0 and 1 keep the pin an input.
    wr(scm_pkg::CH_STRIDE + scm_pkg::OFF_CONFIG_TWO, 32'h0000_0003, r);
    for (int m = 0; m < 8; m++) begin
      wr(scm_pkg::CH_STRIDE + scm_pkg::OFF_CONFIG_ONE, 32'(m), r);
      chk(32'(r), 32'(scm_pkg::RESP_OKAY));
      repeat (70) @(posedge aclk);
      chk(32'(pin_out[1].tx_clk_oe), 32'(m > 1));
    end
    $display("test modes done");
    stop_test();
  end
endmodule : scm_clock_slot_tb
